// ==== hw/spisb_core.sv ====
// status flags, data register and receive buffering of the serial peripheral
//
// Contract
// - receive flag set when word reaches data
// - transmit empty flag high while buffer free
// - mode fault on select low as master
// - mode fault cleared: status read, control write
// - status at offset three, writes ignored
// - narrow width: status read then low read
// - status read then low write clears empty
// - data writes ignored while buffer full
// - high writes keep empty flag unchanged
// - data high four, low five, reset zero
// - queued word offered straight after the low write
// - free flag: move word, set flag
// - busy flag: second word waits in shifter
// - serviced early: waiting word moves, flag stays
// - serviced late: waiting word is discarded
// - word length follows width select
// - mode fault with enable requests interrupt
`timescale 1ns/1ns
module spisb_core
   import spisb_pkg::*;
(
   input  wire logic       core_clk,     // bus clock
   input  wire logic       rst_n,        // synchronous reset, active low
   input  wire logic [2:0] reg_addr,     // register offset
   input  wire logic [7:0] reg_wdata,    // write data
   input  wire logic       reg_wr,       // write strobe
   input  wire logic       reg_rd,       // read strobe
   output logic      [7:0] reg_rdata,    // read data, cycle after strobe
   input  wire spisb_rx_s  eng_rx,       // events from the shift engine
   input  wire logic       eng_tx_take,  // engine took the queued word
   output spisb_tx_s       eng_tx,       // queued word to the engine
   input  wire logic       ss_n_pin,     // slave select pin, active low
   output logic            master_mode,  // master selected
   output logic            irq           // interrupt request, active high
);

   // control registers
   logic [7:0]  ctrl_one_q;         // control_reg_one
   logic [7:0]  ctrl_two_q;         // control_reg_two
   // flags
   logic        rx_complete_flag_q; // receive complete
   logic        tx_empty_flag_q;    // transmit buffer free
   logic        mode_fault_flag_q;  // mode fault seen
   // arming of the clearing sequences, set by a status read
   logic        rx_armed_q;         // status read saw receive flag
   logic        tx_armed_q;         // status read saw empty flag
   logic        mf_armed_q;         // status read saw mode fault
   // data path
   logic [15:0] rx_data_q;          // received data shown to software
   logic [15:0] rx_wait_q;          // word held back in the shifter
   logic        rx_wait_valid_q;    // held word still good
   logic        rx_wait_old_q;      // a transmission began since it arrived
   logic [7:0]  tx_high_q;          // staged high byte
   logic [15:0] tx_word_q;          // queued word
   logic        tx_valid_q;         // queued word waiting
   // select pin synchroniser
   logic        ss_meta_q;          // first stage, read only by second
   logic        ss_sync_q;          // synchronised select level

   // decoded strobes
   logic        wr_ctrl_one;
   logic        wr_ctrl_two;
   logic        wr_high;
   logic        wr_low;
   logic        rd_status;
   logic        rd_low;
   logic        wide;
   logic        rx_clear;
   logic        mf_detect;
   logic        tx_load;
   logic [7:0]  status_val;

   // address match, shared by every strobe decode
   function automatic logic hit(input logic [2:0] a, input logic [2:0] off);
      return a == off;
   endfunction

   assign wr_ctrl_one = reg_wr && hit(reg_addr, SPISB_OFF_CTRL_ONE);
   assign wr_ctrl_two = reg_wr && hit(reg_addr, SPISB_OFF_CTRL_TWO);
   // data writes while the buffer is full fall on the floor
   assign wr_high     = reg_wr && hit(reg_addr, SPISB_OFF_DATA_HIGH) && tx_empty_flag_q;
   assign wr_low      = reg_wr && hit(reg_addr, SPISB_OFF_DATA_LOW) && tx_empty_flag_q;
   assign rd_status   = reg_rd && hit(reg_addr, SPISB_OFF_STATUS);
   assign rd_low      = reg_rd && hit(reg_addr, SPISB_OFF_DATA_LOW);
   assign wide        = ctrl_two_q[SPISB_C2_WIDTH_SELECT];

   // only the low byte read finishes the receive sequence, in both widths
   assign rx_clear    = rd_low && rx_armed_q && rx_complete_flag_q;
   // only the low byte write finishes the transmit sequence
   assign tx_load     = wr_low && tx_armed_q;

   // mode fault needs master, detection on and select pulled low
   assign mf_detect   = ctrl_one_q[SPISB_C1_MASTER_SELECT] && ctrl_two_q[SPISB_C2_MODE_FAULT_ENABLE]
                        && !ss_sync_q;

   // status image, unused bits read zero
   always_comb begin
      status_val = 8'h00;
      status_val[SPISB_ST_RX_COMPLETE] = rx_complete_flag_q;
      status_val[SPISB_ST_TX_EMPTY]    = tx_empty_flag_q;
      status_val[SPISB_ST_MODE_FAULT]  = mode_fault_flag_q;
   end

   // select pin passes two flops before use
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ss_meta_q <= 1'b1;
         ss_sync_q <= 1'b1;
      end else begin
         ss_meta_q <= ss_n_pin;
         ss_sync_q <= ss_meta_q;
      end
   end

   // control_reg_one; a mode fault drops master select
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_one_q <= SPISB_CTRL_ONE_RST;
      end else begin
         if (wr_ctrl_one) begin
            ctrl_one_q <= reg_wdata;
         end
         // fault forces slave, even over a same-cycle write
         if (mf_detect) begin
            ctrl_one_q[SPISB_C1_MASTER_SELECT] <= 1'b0;
         end
      end
   end

   // control_reg_two
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         ctrl_two_q <= SPISB_CTRL_TWO_RST;
      end else if (wr_ctrl_two) begin
         ctrl_two_q <= reg_wdata;
      end
   end

   // arming: a status read records which flags it saw
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_armed_q <= 1'b0;
         tx_armed_q <= 1'b0;
         mf_armed_q <= 1'b0;
      end else begin
         if (rd_status) begin
            rx_armed_q <= rx_complete_flag_q;
            tx_armed_q <= tx_empty_flag_q;
            mf_armed_q <= mode_fault_flag_q;
         end else begin
            // a finished sequence disarms, so a second access does nothing
            if (rx_clear) begin
               rx_armed_q <= 1'b0;
            end
            if (tx_load) begin
               tx_armed_q <= 1'b0;
            end
            if (wr_ctrl_one) begin
               mf_armed_q <= 1'b0;
            end
         end
      end
   end

   // mode fault flag, set beats clear
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         mode_fault_flag_q <= 1'b0;
      end else if (mf_detect) begin
         mode_fault_flag_q <= 1'b1;
      end else if (wr_ctrl_one && mf_armed_q) begin
         mode_fault_flag_q <= 1'b0;
      end
   end

   // receive flag and data register
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_complete_flag_q <= 1'b0;
         rx_data_q          <= SPISB_DATA_RST;
      end else begin
         if (eng_rx.done && (!rx_complete_flag_q || rx_clear)) begin
            // free or freed this cycle: the new word goes straight up
            rx_data_q          <= wide ? eng_rx.word : {8'h00, eng_rx.word[7:0]};
            rx_complete_flag_q <= 1'b1;
         end else if (rx_clear && rx_wait_valid_q && !rx_wait_old_q) begin
            // early service promotes the held word and keeps the flag
            rx_data_q          <= rx_wait_q;
            rx_complete_flag_q <= 1'b1;
         end else if (rx_clear) begin
            rx_complete_flag_q <= 1'b0;
         end
      end
   end

   // held word in the receive shifter
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         rx_wait_q       <= SPISB_DATA_RST;
         rx_wait_valid_q <= 1'b0;
         rx_wait_old_q   <= 1'b0;
      end else begin
         if (eng_rx.done && rx_complete_flag_q && !rx_clear) begin
            // second word while the flag is busy: keep it below
            rx_wait_q       <= wide ? eng_rx.word : {8'h00, eng_rx.word[7:0]};
            rx_wait_valid_q <= 1'b1;
            rx_wait_old_q   <= 1'b0;
         end else if (rx_clear) begin
            // promoted or stale, either way it leaves the shifter
            rx_wait_valid_q <= 1'b0;
         end else if (eng_rx.start && rx_wait_valid_q) begin
            // the shifter is reused, the held word is lost
            rx_wait_old_q   <= 1'b1;
            rx_wait_valid_q <= 1'b0;
         end
      end
   end

   // transmit staging and empty flag
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         tx_high_q       <= 8'h00;
         tx_word_q       <= SPISB_DATA_RST;
         tx_valid_q      <= 1'b0;
         tx_empty_flag_q <= SPISB_TX_EMPTY_RST;
      end else begin
         if (wr_high) begin
            tx_high_q <= reg_wdata;
         end
         if (tx_load) begin
            // lone low write sends whatever high byte is staged
            tx_word_q       <= {tx_high_q, reg_wdata};
            tx_valid_q      <= 1'b1;
            tx_empty_flag_q <= 1'b0;
         end else if (eng_tx_take && tx_valid_q) begin
            tx_valid_q      <= 1'b0;
            tx_empty_flag_q <= 1'b1;
         end
      end
   end

   // register read port, data stands one cycle after the strobe
   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            SPISB_OFF_CTRL_ONE:  reg_rdata <= ctrl_one_q;
            SPISB_OFF_CTRL_TWO:  reg_rdata <= ctrl_two_q;
            SPISB_OFF_STATUS:    reg_rdata <= status_val;
            SPISB_OFF_DATA_HIGH: reg_rdata <= rx_data_q[15:8];
            SPISB_OFF_DATA_LOW:  reg_rdata <= rx_data_q[7:0];
            default:             reg_rdata <= 8'h00; // unmapped reads zero
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // engine offer: valid holds until taken, engine starts at once as master
   always_comb begin
      eng_tx.valid = tx_valid_q;
      eng_tx.word  = tx_word_q;
      eng_tx.bits  = wide ? SPISB_BITS_WIDE : SPISB_BITS_NARROW;
   end

   assign master_mode = ctrl_one_q[SPISB_C1_MASTER_SELECT];

   // one request line, each flag gated by its enable
   assign irq = (ctrl_one_q[SPISB_C1_IRQ_ENABLE] && (mode_fault_flag_q || rx_complete_flag_q))
                || (ctrl_one_q[SPISB_C1_TX_IRQ_ENABLE] && tx_empty_flag_q);

endmodule

// ==== hw/spisb_pkg.sv ====
// shared constants, field layout and carrier types of the serial status and data buffer
package spisb_pkg;
   // register offsets on the local register port
   localparam logic [2:0] SPISB_OFF_CTRL_ONE  = 3'h0; // control_reg_one
   localparam logic [2:0] SPISB_OFF_CTRL_TWO  = 3'h1; // control_reg_two
   localparam logic [2:0] SPISB_OFF_STATUS    = 3'h3; // serial_status, read only
   localparam logic [2:0] SPISB_OFF_DATA_HIGH = 3'h4; // serial_data_high
   localparam logic [2:0] SPISB_OFF_DATA_LOW  = 3'h5; // serial_data_low

   // serial_status bit positions
   localparam int SPISB_ST_RX_COMPLETE = 7;
   localparam int SPISB_ST_TX_EMPTY    = 5;
   localparam int SPISB_ST_MODE_FAULT  = 4;

   // control_reg_one bit positions
   localparam int SPISB_C1_IRQ_ENABLE    = 7;
   localparam int SPISB_C1_TX_IRQ_ENABLE = 5;
   localparam int SPISB_C1_MASTER_SELECT = 4;

   // control_reg_two bit positions
   localparam int SPISB_C2_WIDTH_SELECT     = 6;
   localparam int SPISB_C2_MODE_FAULT_ENABLE = 4;

   // reset values
   localparam logic [7:0]  SPISB_CTRL_ONE_RST = 8'h00;
   localparam logic [7:0]  SPISB_CTRL_TWO_RST = 8'h00;
   localparam logic [15:0] SPISB_DATA_RST     = 16'h0000;
   localparam logic        SPISB_TX_EMPTY_RST = 1'b1;

   // word lengths handed to the shift engine
   localparam logic [4:0] SPISB_BITS_NARROW = 5'h08;
   localparam logic [4:0] SPISB_BITS_WIDE   = 5'h10;

   // events coming back from the shift engine
   typedef struct packed {
      logic        start; // a transmission begins
      logic        done;  // a transmission ended, word below is valid
      logic [15:0] word;  // received word, right aligned
   } spisb_rx_s;

   // queued word offered to the shift engine
   typedef struct packed {
      logic        valid; // a word is waiting to be sent
      logic [15:0] word;  // word to send
      logic [4:0]  bits;  // bit positions per transfer
   } spisb_tx_s;
endpackage

// ==== verif/spisb_core_sva.sv ====
// assertion checker watching the ports of the serial status and data buffer
`timescale 1ns/1ns
module spisb_core_sva
   import spisb_pkg::*;
(
   input wire logic       core_clk,
   input wire logic       rst_n,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_wr,
   input wire logic       reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire spisb_rx_s  eng_rx,
   input wire logic       eng_tx_take,
   input wire spisb_tx_s  eng_tx,
   input wire logic       ss_n_pin,
   input wire logic       master_mode,
   input wire logic       irq
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   logic st_rd; // status read this cycle
   logic lo_wr; // low data byte write this cycle
   logic c1_wr; // control one write, the only legal way besides a mode fault to drop master
   assign st_rd = reg_rd && reg_addr == SPISB_OFF_STATUS;
   assign lo_wr = reg_wr && reg_addr == SPISB_OFF_DATA_LOW;
   assign c1_wr = reg_wr && reg_addr == SPISB_OFF_CTRL_ONE;
   rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read");
   unused_bits_a: assert property (st_rd |=> reg_rdata[6] == 1'b0 && reg_rdata[3:0] == 4'h0)
      else $error("unused status bits set");
   empty_mirror_a: assert property (st_rd |=> reg_rdata[SPISB_ST_TX_EMPTY] == !$past(eng_tx.valid))
      else $error("empty flag disagrees with queue");
   done_flag_a: assert property (eng_rx.done ##1 !reg_rd ##1 st_rd |=> reg_rdata[SPISB_ST_RX_COMPLETE])
      else $error("receive flag missing after word");
   tx_hold_a: assert property (eng_tx.valid && !eng_tx_take |=> eng_tx.valid)
      else $error("queued word dropped without take");
   take_frees_a: assert property (eng_tx.valid && eng_tx_take |=> !eng_tx.valid)
      else $error("queue not freed after take");
   tx_load_a: assert property ($rose(eng_tx.valid) |-> $past(lo_wr) && eng_tx.word[7:0] == $past(reg_wdata))
      else $error("queue filled without low write");
   width_bits_a: assert property (eng_tx.bits == SPISB_BITS_NARROW || eng_tx.bits == SPISB_BITS_WIDE)
      else $error("word length neither 8 nor 16");
   fault_cause_a: assert property ($fell(master_mode) |->
      $past(c1_wr) || !$past(ss_n_pin, 2) || !$past(ss_n_pin, 3) || !$past(ss_n_pin, 4))
      else $error("master dropped without cause");
   cover property (st_rd ##1 reg_rdata[SPISB_ST_RX_COMPLETE]);
   cover property ($fell(master_mode));
   cover property (eng_tx.valid && eng_tx_take);
endmodule

bind spisb_core spisb_core_sva spisb_core_sva_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr),
   .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_rx(eng_rx),
   .eng_tx_take(eng_tx_take), .eng_tx(eng_tx), .ss_n_pin(ss_n_pin), .master_mode(master_mode), .irq(irq));

// ==== verif/spisb_eng_model.sv ====
// shift engine stand-in reporting transfers to the buffer
`timescale 1ns/1ns
module spisb_eng_model
   import spisb_pkg::*;
(
   output spisb_rx_s      eng_rx,
   output logic           eng_tx_take,
   input  wire logic      core_clk,
   input  wire spisb_tx_s eng_tx
);
   initial begin
      eng_rx = '0;
      eng_tx_take = 1'b0;
   end
   // one transfer: start, shift cycles, then the word unless cut short
   task automatic xfer(input logic [15:0] w, input logic fin);
      @(posedge core_clk);
      eng_rx.start <= 1'b1;
      eng_tx_take <= eng_tx.valid; // queued word leaves at once
      @(posedge core_clk);
      eng_rx.start <= 1'b0;
      eng_tx_take <= 1'b0;
      repeat (3) @(posedge core_clk);
      if (fin) begin
         eng_rx.done <= 1'b1;
         eng_rx.word <= w;
         @(posedge core_clk);
         eng_rx.done <= 1'b0;
         eng_rx.word <= ~w; // stale word scrambled so nobody relies on it
      end
   endtask
endmodule

// ==== verif/tb.sv ====
// self-checking bench for the serial status and data buffer
`timescale 1ns/1ns
module tb;
   import spisb_pkg::*;
   logic       core_clk, rst_n, reg_wr, reg_rd, ss_n_pin, eng_tx_take, master_mode, irq;
   logic [2:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata;
   spisb_rx_s  eng_rx;
   spisb_tx_s  eng_tx;
   int         n_errors = 0;
   int         tests_run = 0;

   spisb_core spisb_core_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .eng_rx(eng_rx), .eng_tx_take(eng_tx_take),
      .eng_tx(eng_tx), .ss_n_pin(ss_n_pin), .master_mode(master_mode), .irq(irq));
   spisb_eng_model spisb_eng_model_i (.eng_rx(eng_rx), .eng_tx_take(eng_tx_take), .core_clk(core_clk),
      .eng_tx(eng_tx));

   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   // compare and count; case inequality so unknowns never match
   task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // one-cycle write, settles past the edge before returning
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // one-cycle read, data looked at only in the following cycle
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      chk("reg read", {8'h00, reg_rdata}, {8'h00, exp});
   endtask
   task automatic complete_run();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   // watchdog: a hang counts as a mismatch
   initial begin
      repeat (20000) @(posedge core_clk);
      n_errors++;
      complete_run();
   end
   initial begin
      {rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, ss_n_pin} = 15'h0001;
      repeat (20) @(posedge core_clk);
      rst_n <= 1'b1;
      rd(3'h3, 8'h20);
      wr(3'h3, 8'hff);
      rd(3'h3, 8'h20);
      rd(3'h4, 8'h00);
      $display("test reset done");
      // second word waits behind a set flag, software reads only while flagged
      spisb_eng_model_i.xfer(16'h0011, 1'b1);
      spisb_eng_model_i.xfer(16'h0022, 1'b1);
      rd(3'h3, 8'ha0);
      rd(3'h5, 8'h11);
      rd(3'h3, 8'ha0);
      rd(3'h5, 8'h22);
      rd(3'h3, 8'h20);
      $display("test receive buffer done");
      // third start before service loses the waiting word
      spisb_eng_model_i.xfer(16'h0033, 1'b1);
      spisb_eng_model_i.xfer(16'h0044, 1'b1);
      spisb_eng_model_i.xfer(16'h0000, 1'b0);
      rd(3'h3, 8'ha0);
      rd(3'h5, 8'h33);
      rd(3'h3, 8'h20);
      $display("test late service done");
      rd(3'h3, 8'h20);
      wr(3'h5, 8'h5a);
      chk("queue", {7'h00, eng_tx.valid, eng_tx.word[7:0]}, 16'h015a);
      wr(3'h5, 8'h77);
      chk("queue", {7'h00, eng_tx.valid, eng_tx.word[7:0]}, 16'h015a);
      spisb_eng_model_i.xfer(16'h0066, 1'b1);
      rd(3'h3, 8'ha0);
      rd(3'h5, 8'h66);
      $display("test transmit done");
      wr(3'h1, 8'h40);
      chk("bits", {11'h000, eng_tx.bits}, 16'h0010);
      spisb_eng_model_i.xfer(16'hbeef, 1'b1);
      rd(3'h3, 8'ha0);
      rd(3'h4, 8'hbe);
      rd(3'h3, 8'ha0);
      rd(3'h5, 8'hef);
      rd(3'h3, 8'h20);
      // lone low read in wide width: software gives up the high byte
      spisb_eng_model_i.xfer(16'h1234, 1'b1);
      rd(3'h3, 8'ha0);
      rd(3'h5, 8'h34);
      rd(3'h3, 8'h20);
      $display("test wide done");
      // repeated high writes keep the buffer free, low write queues staged high
      wr(3'h4, 8'hc3);
      wr(3'h4, 8'hc4);
      rd(3'h3, 8'h20);
      wr(3'h5, 8'h3c);
      chk("queue word", eng_tx.word, 16'hc43c);
      spisb_eng_model_i.xfer(16'h0000, 1'b0);
      chk("queue drained", {15'h0000, eng_tx.valid}, 16'h0000);
      wr(3'h0, 8'h20);
      chk("tx irq", {15'h0000, irq}, 16'h0001);
      $display("test high staging done");
      wr(3'h1, 8'h10);
      wr(3'h0, 8'h90);
      @(posedge core_clk);
      ss_n_pin <= 1'b0;
      repeat (6) @(posedge core_clk);
      ss_n_pin <= 1'b1;
      rd(3'h3, 8'h30);
      chk("master irq", {14'h0000, master_mode, irq}, 16'h0001);
      wr(3'h0, 8'h80);
      rd(3'h3, 8'h20);
      chk("master irq", {14'h0000, master_mode, irq}, 16'h0000);
      $display("test mode fault done");
      complete_run();
   end
endmodule
